// ==== core/sid_pkg.sv ====
`default_nettype none
package sid_pkg;
	// Register offsets on the local register port.
	localparam logic [7:0] SID_OFF_TRIGGER = 8'h00;
	localparam logic [7:0] SID_OFF_CTRL = 8'h04;
	localparam logic [7:0] SID_OFF_GROUP = 8'h08;
	localparam logic [7:0] SID_OFF_STATUS = 8'h0c;

	// Trigger word layout.
	localparam int SID_FILT_HI = 25;
	localparam int SID_FILT_LO = 24;
	localparam int SID_MASK_HI = 23;
	localparam int SID_MASK_LO = 16;
	localparam int SID_GSEL_BIT = 15;
	localparam int SID_NUM_HI = 3;
	localparam int SID_NUM_LO = 0;

	// Control word layout and reset value.
	localparam int SID_CTRL_EN_BIT = 0;
	localparam logic [31:0] SID_CTRL_RST = 32'h0000_0001;

	// Status word layout.
	localparam int SID_STAT_MASK_LO = 0;
	localparam int SID_STAT_NUM_LO = 8;
	localparam int SID_STAT_SRC_LO = 12;
	localparam int SID_STAT_CNT_LO = 16;

	// Group bank reset value and sizes.
	localparam logic [15:0] SID_GROUP_RST = 16'h0000;
	localparam int SID_MAX_CPU = 8;
	localparam int SID_NUM_IRQ = 16;

	typedef enum logic [1:0] {
		SID_FILT_LIST = 2'h0,
		SID_FILT_OTHERS = 2'h1,
		SID_FILT_SELF = 2'h2,
		SID_FILT_RSVD = 2'h3
	} sid_filt_t;
endpackage
`default_nettype wire

// ==== core/sid_req_if.sv ====
`default_nettype none
interface sid_req_if;
	import sid_pkg::*;
	logic valid;
	sid_filt_t filter;
	logic [7:0] mask;
	logic [3:0] num;
	logic secure;
	logic group_sel;
	logic [2:0] src;

	modport src_mp (output valid, output filter, output mask, output num,
		output secure, output group_sel, output src);
	modport dst_mp (input valid, input filter, input mask, input num,
		input secure, input group_sel, input src);
endinterface
`default_nettype wire

// ==== core/sid_fwd_slice.sv ====
`default_nettype none
module sid_fwd_slice
	import sid_pkg::*;
#(
	parameter int IDX = 0,
	parameter bit SEC_EXT = 1'b1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	sid_req_if.dst_mp req,
	input wire logic grp_bit,
	output logic hit
);
	localparam logic [2:0] MY_ID = 3'(IDX);

	logic targeted;
	logic group_ok;

	always_comb begin
		unique case (req.filter)
			SID_FILT_LIST: targeted = req.mask[IDX]; // see [R2] see [R5] see [R6] see [R7]
			SID_FILT_OTHERS: targeted = (req.src != MY_ID); // see [R3]
			SID_FILT_SELF: targeted = (req.src == MY_ID); // see [R4]
			SID_FILT_RSVD: targeted = 1'b0; // see [R1] see [R18]
		endcase
	end

	// Each slice judges with its own processor's banked group bit.
	always_comb begin
		if (!SEC_EXT) begin
			group_ok = 1'b1;
		end else if (req.secure) begin
			group_ok = (grp_bit == req.group_sel); // see [R14] see [R16]
		end else begin
			group_ok = grp_bit; // see [R15]
		end
	end

	assign hit = req.valid && targeted && group_ok;

	AST_SLICE_NONSECURE: assert property (@(posedge mclk) disable iff (sys_rst) // see [R15]
		(SEC_EXT && hit && !req.secure) |-> grp_bit)
		else $error("non-secure trigger hit a group 0 target");

	AST_SLICE_SECURE: assert property (@(posedge mclk) disable iff (sys_rst) // see [R14]
		(SEC_EXT && req.valid && req.secure && (grp_bit != req.group_sel)) |-> !hit)
		else $error("secure trigger ignored the group select");
endmodule // sid_fwd_slice
`default_nettype wire

// ==== core/sid_dispatch.sv ====
// Added by the designer: the register addresses and strobed register access.
`default_nettype none
// Operation
// [R1] Filter field bits 25:24 selects distribution
// [R2] Filter 00 forwards to mask-selected interfaces
// [R3] Filter 01 forwards to all but requester
// [R4] Filter 10 forwards to requester only
// [R5] Mask bits 23:16, bit n is interface n
// [R6] Mask bit one delivers to that interface
// [R7] Mask used only when filter is 00
// [R8] Filter 00 with zero mask delivers nothing
// [R9] Group select bit exists only with security
// [R10] One trigger register shared by both states
// [R11] Trigger always present; disabled forwarding drops it
// [R12] Trigger exists in every build
// [R13] Interrupt number from bits 3:0
// [R14] Secure write needs group equal to select
// [R15] Non-secure write needs group 1 target
// [R16] Decision per target with its banked groups
// [R17] Reserved bits ignored, software writes zero
// [R18] Reserved filter delivers to nobody
module sid_dispatch
	import sid_pkg::*;
#(
	parameter int NCPU = 8,
	parameter bit SEC_EXT = 1'b1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata_q,
	input wire logic [2:0] req_cpu_id,
	input wire logic req_secure,
	output logic [NCPU-1:0] irq_deliver_q,
	output logic [3:0] irq_num_q,
	output logic [2:0] irq_src_q,
	output logic fwd_enable_q
);
	localparam logic [3:0] NCPU_W = 4'(NCPU);

	if (NCPU < 1 || NCPU > SID_MAX_CPU) begin : g_bad_ncpu
		$error("NCPU must lie between 1 and 8");
	end

	sid_req_if req ();

	logic trig_wr;
	logic trig_take;
	logic src_valid;
	logic [NCPU-1:0] hit;
	logic [15:0] grp_q [NCPU];
	logic [7:0] last_mask_q;
	logic [3:0] last_num_q;
	logic [2:0] last_src_q;
	logic [15:0] trig_cnt_q;
	logic [7:0] hit8;
	logic [31:0] rdata_d;

	assign src_valid = ({1'b0, req_cpu_id} < NCPU_W);

	// A single trigger decode serves secure and non-secure writers alike; it is
	// not banked and exists whatever options are built in.
	assign trig_wr = bus_wr && (bus_addr == SID_OFF_TRIGGER); // see [R10] see [R12]
	// Writes while forwarding is off are dropped, not queued for later.
	assign trig_take = trig_wr && fwd_enable_q; // see [R11]

	// Only the named fields are passed on; bits 31:26 and 14:4 never reach the
	// slices, so a stray one in software cannot change delivery.
	always_comb begin // see [R17]
		req.valid = trig_take;
		req.filter = sid_filt_t'(bus_wdata[SID_FILT_HI:SID_FILT_LO]); // see [R1]
		req.mask = bus_wdata[SID_MASK_HI:SID_MASK_LO]; // see [R5]
		req.num = bus_wdata[SID_NUM_HI:SID_NUM_LO]; // see [R13]
		req.secure = SEC_EXT ? req_secure : 1'b1;
		req.group_sel = SEC_EXT ? bus_wdata[SID_GSEL_BIT] : 1'b0; // see [R9]
		req.src = req_cpu_id;
	end

	for (genvar i = 0; i < NCPU; i++) begin : g_slice
		sid_fwd_slice #(
			.IDX(i),
			.SEC_EXT(SEC_EXT)
		) u_slice (
			.mclk(mclk),
			.sys_rst(sys_rst),
			.req(req),
			.grp_bit(grp_q[i][req.num]), // see [R16]
			.hit(hit[i])
		);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_deliver_q <= '0;
			irq_num_q <= 4'h0;
			irq_src_q <= 3'h0;
		end else begin
			irq_deliver_q <= hit;
			if (trig_take) begin
				irq_num_q <= req.num;
				irq_src_q <= req.src;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fwd_enable_q <= SID_CTRL_RST[SID_CTRL_EN_BIT];
		end else if (bus_wr && bus_addr == SID_OFF_CTRL) begin
			fwd_enable_q <= bus_wdata[SID_CTRL_EN_BIT];
		end
	end

	// Each processor reaches its own group bank at one shared offset. With the
	// security option only secure writes may change it.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int i = 0; i < NCPU; i++) begin
				grp_q[i] <= SID_GROUP_RST;
			end
		end else if (bus_wr && bus_addr == SID_OFF_GROUP && src_valid &&
			(!SEC_EXT || req_secure)) begin
			grp_q[req_cpu_id] <= bus_wdata[SID_NUM_IRQ-1:0];
		end
	end

	always_comb begin
		hit8 = 8'h00;
		hit8[NCPU-1:0] = hit;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			last_mask_q <= 8'h00;
			last_num_q <= 4'h0;
			last_src_q <= 3'h0;
			trig_cnt_q <= 16'h0000;
		end else if (trig_take) begin
			last_mask_q <= hit8;
			last_num_q <= req.num;
			last_src_q <= req.src;
			trig_cnt_q <= trig_cnt_q + 16'h0001;
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (bus_rd) begin
			unique case (bus_addr)
				SID_OFF_CTRL: rdata_d[SID_CTRL_EN_BIT] = fwd_enable_q;
				SID_OFF_GROUP: begin
					if (src_valid) begin
						rdata_d[SID_NUM_IRQ-1:0] = grp_q[req_cpu_id];
					end
				end
				SID_OFF_STATUS: begin
					rdata_d[SID_STAT_MASK_LO +: 8] = last_mask_q;
					rdata_d[SID_STAT_NUM_LO +: 4] = last_num_q;
					rdata_d[SID_STAT_SRC_LO +: 3] = last_src_q;
					rdata_d[SID_STAT_CNT_LO +: 16] = trig_cnt_q;
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus_rdata_q <= 32'h0000_0000;
		end else begin
			bus_rdata_q <= rdata_d;
		end
	end

	// Helper copies of the taken trigger, read only by the checks below.
	logic take_h;
	logic [31:0] wd_h;
	logic [2:0] src_h;
	logic sec_h;
	logic off_wr_h;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			take_h <= 1'b0;
			wd_h <= 32'h0000_0000;
			src_h <= 3'h0;
			sec_h <= 1'b0;
			off_wr_h <= 1'b0;
		end else begin
			take_h <= trig_take;
			wd_h <= bus_wdata;
			src_h <= req_cpu_id;
			sec_h <= req_secure;
			off_wr_h <= trig_wr && !fwd_enable_q;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	logic [NCPU-1:0] mask_h;
	logic [NCPU-1:0] self_h;
	assign mask_h = wd_h[SID_MASK_LO +: NCPU];
	assign self_h = NCPU'(1) << src_h;

	// Group bits of the taken number, one per target. No group write can land in the
	// same edge as a trigger, so the banks still hold what the trigger was judged by.
	logic [NCPU-1:0] grp_col_h;
	logic [NCPU-1:0] ok_vec_h;

	always_comb begin
		grp_col_h = '0;
		for (int i = 0; i < NCPU; i++) begin
			grp_col_h[i] = grp_q[i][wd_h[SID_NUM_HI:SID_NUM_LO]];
		end
	end

	always_comb begin
		if (!SEC_EXT) begin
			ok_vec_h = '1;
		end else if (sec_h) begin
			ok_vec_h = ~(grp_col_h ^ {NCPU{wd_h[SID_GSEL_BIT]}});
		end else begin
			ok_vec_h = grp_col_h;
		end
	end

	AST_FILT_RSVD: assert property ( // see [R18]
		(take_h && wd_h[SID_FILT_HI:SID_FILT_LO] == 2'h3) |-> (irq_deliver_q == '0))
		else $error("reserved filter delivered an interrupt");

	AST_LIST_SUBSET: assert property ( // see [R7]
		(take_h && wd_h[SID_FILT_HI:SID_FILT_LO] == 2'h0) |-> ((irq_deliver_q & ~mask_h) == '0))
		else $error("list filter reached an unselected interface");

	AST_LIST_EXACT: assert property ( // see [R6]
		(take_h && wd_h[SID_FILT_HI:SID_FILT_LO] == 2'h0) |->
		(irq_deliver_q == (mask_h & ok_vec_h)))
		else $error("list filter missed a selected interface");

	AST_LIST_EMPTY: assert property ( // see [R8]
		(take_h && wd_h[SID_FILT_HI:SID_FILT_LO] == 2'h0 && wd_h[SID_MASK_HI:SID_MASK_LO] == 8'h00)
		|-> (irq_deliver_q == '0))
		else $error("empty mask still delivered");

	AST_OTHERS_SKIP_SELF: assert property ( // see [R3]
		(take_h && wd_h[SID_FILT_HI:SID_FILT_LO] == 2'h1) |-> ((irq_deliver_q & self_h) == '0))
		else $error("others filter reached the requester");

	AST_OTHERS_ALL: assert property ( // see [R3]
		(take_h && wd_h[SID_FILT_HI:SID_FILT_LO] == 2'h1) |->
		(irq_deliver_q == (~self_h & ok_vec_h)))
		else $error("others filter missed an interface");

	AST_SELF_ONLY: assert property ( // see [R4]
		(take_h && wd_h[SID_FILT_HI:SID_FILT_LO] == 2'h2) |-> ((irq_deliver_q & ~self_h) == '0))
		else $error("self filter reached another interface");

	AST_DISABLED_DROP: assert property ( // see [R11]
		off_wr_h |-> (irq_deliver_q == '0) ##1 (trig_cnt_q == $past(trig_cnt_q)))
		else $error("trigger acted while forwarding was off");

	AST_NUMBER: assert property ( // see [R13]
		take_h |-> (irq_num_q == wd_h[SID_NUM_HI:SID_NUM_LO] && irq_src_q == src_h))
		else $error("delivered number or source differs from the write");

	AST_PULSE: assert property ( // see [R2]
		(irq_deliver_q != '0) && !trig_take |=> (irq_deliver_q == '0))
		else $error("delivery held longer than one cycle");

	AST_NONSEC_NOSEL: assert property ( // see [R9]
		(take_h && !(SEC_EXT && sec_h)) |-> ((irq_deliver_q & ~ok_vec_h) == '0))
		else $error("non-secure trigger depended on the select bit");

	AST_SELF_EXACT: assert property ( // see [R4]
		(take_h && wd_h[SID_FILT_HI:SID_FILT_LO] == 2'h2) |->
		(irq_deliver_q == (self_h & ok_vec_h)))
		else $error("self filter missed the requester");

	AST_NUM_HOLD: assert property ( // see [R13]
		!trig_take |=> ($stable(irq_num_q) && $stable(irq_src_q)))
		else $error("number or source changed without a trigger");

	AST_COUNT_STEP: assert property ( // see [R11]
		trig_take |=> (trig_cnt_q == $past(trig_cnt_q) + 16'h0001))
		else $error("taken trigger was not counted once");

	AST_ENABLE_WRITE: assert property ( // see [R11]
		(bus_wr && bus_addr == SID_OFF_CTRL) |=>
		(fwd_enable_q == $past(bus_wdata[SID_CTRL_EN_BIT])))
		else $error("forwarding enable did not follow the control write");
endmodule // sid_dispatch
`default_nettype wire

// ==== verif/sid_cpu_model.sv ====
`default_nettype none
module sid_cpu_model
	import sid_pkg::*;
#(
	parameter int NCPU = 8
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [NCPU-1:0] irq_deliver_q,
	input wire logic [3:0] irq_num_q,
	output logic [NCPU-1:0][15:0] pend_q
);
	// Each CPU interface only sets pending flags on delivery; only reset clears them.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pend_q <= '0;
		end else begin
			for (int i = 0; i < NCPU; i++) begin
				if (irq_deliver_q[i]) begin
					pend_q[i][irq_num_q] <= 1'b1;
				end
			end
		end
	end
endmodule // sid_cpu_model
`default_nettype wire

// ==== verif/soft_irq_dispatch_tb.sv ====
`default_nettype none
module soft_irq_dispatch_tb
	import sid_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [2:0] req_cpu_id = 3'h0;
	logic req_secure = 1'b0;
	logic [31:0] bus_rdata_q;
	logic [7:0] irq_deliver_q;
	logic [3:0] irq_num_q;
	logic [2:0] irq_src_q;
	logic fwd_enable_q;
	logic [7:0][15:0] pend_q;
	logic [7:0][15:0] grp = '0;
	logic [7:0][15:0] epend = '0;
	logic [31:0] dq[$];
	logic [31:0] rq[$];
	logic [31:0] lst = 32'h0;
	logic [31:0] d;
	logic trig_p = 1'b0;
	logic rd_p = 1'b0;
	logic en = 1'b1;
	logic en_e = SID_CTRL_RST[SID_CTRL_EN_BIT];
	int err_count = 0;
	int comparisons = 0;
	int cnt = 0;

	always #4 mclk = ~mclk;

	sid_dispatch #(.NCPU(8), .SEC_EXT(1'b1)) DUT (.mclk(mclk), .sys_rst(sys_rst),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata_q(bus_rdata_q), .req_cpu_id(req_cpu_id), .req_secure(req_secure),
		.irq_deliver_q(irq_deliver_q), .irq_num_q(irq_num_q), .irq_src_q(irq_src_q),
		.fwd_enable_q(fwd_enable_q));
	sid_cpu_model #(.NCPU(8)) cpus (.mclk(mclk), .sys_rst(sys_rst),
		.irq_deliver_q(irq_deliver_q), .irq_num_q(irq_num_q), .pend_q(pend_q));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("Mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
		input logic [2:0] c, input logic s);
		@(posedge mclk);
		bus_wr <= w;
		bus_rd <= !w;
		bus_addr <= a;
		bus_wdata <= v;
		req_cpu_id <= c;
		req_secure <= s;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0, 3'h0, 1'b1);
	endtask

	task automatic gw(input logic [2:0] c, input logic [31:0] v, input logic s);
		bus(1'b1, SID_OFF_GROUP, v, c, s);
		if (s) begin
			grp[c] = v[15:0];
		end
	endtask

	// The expected mask is built from the field rules alone, then pruned per target.
	task automatic trig(input logic [31:0] v, input logic [2:0] c, input logic s);
		logic [7:0] t;
		logic [3:0] n;
		n = v[3:0];
		case (v[25:24])
			2'h0: t = v[23:16];
			2'h1: t = ~(8'h01 << c);
			2'h2: t = 8'h01 << c;
			default: t = 8'h00;
		endcase
		for (int i = 0; i < 8; i++) begin
			if (s ? grp[i][n] !== v[15] : !grp[i][n]) begin
				t[i] = 1'b0;
			end
		end
		if (en) begin
			lst = {17'h0, c, n, t};
			cnt++;
			for (int i = 0; i < 8; i++) begin
				if (t[i]) begin
					epend[i][n] = 1'b1;
				end
			end
		end
		dq.push_back({lst[31:8], en ? lst[7:0] : 8'h00});
		bus(1'b1, SID_OFF_TRIGGER, v, c, s);
	endtask

	always @(posedge mclk) begin
		trig_p <= bus_wr && bus_addr == SID_OFF_TRIGGER;
		rd_p <= bus_rd;
		if (bus_wr && bus_addr == SID_OFF_CTRL) begin
			en_e <= bus_wdata[SID_CTRL_EN_BIT];
		end
	end

	always @(negedge mclk) begin
		if (trig_p) begin
			chk("trigger", dq.pop_front(), {17'h0, irq_src_q, irq_num_q, irq_deliver_q});
		end else begin
			chk("deliver idle", 32'h0, {24'h0, irq_deliver_q});
		end
		if (rd_p) begin
			chk("read", rq.pop_front(), bus_rdata_q);
		end else begin
			chk("rdata idle", 32'h0, bus_rdata_q);
		end
		chk("enable", {31'h0, en_e}, {31'h0, fwd_enable_q});
	end

	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		stop_test();
	end

	initial begin
		void'($urandom(70));
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(SID_OFF_CTRL, SID_CTRL_RST);
		rd(SID_OFF_TRIGGER, 32'h0);
		rd(8'h10, 32'h0);
		for (int i = 0; i < 8; i++) begin
			gw(i[2:0], $urandom, 1'b1);
		end
		gw(3'h0, ~{16'h0, grp[0]}, 1'b0);
		rd(SID_OFF_GROUP, {16'h0, grp[0]});
		trig(32'h0000_0005, 3'h1, 1'b1);
		for (int i = 0; i < 300; i++) begin
			d = $urandom;
			d[25:24] = i[1:0];
			// 148 of the 300 writes keep reserved bits zero, the rest do not, to show they are ignored.
			if (i[2]) begin
				d[31:26] = 6'h0;
				d[14:4] = 11'h0;
			end
			trig(d, 3'($urandom), 1'($urandom));
		end
		bus(1'b1, SID_OFF_CTRL, 32'h0, 3'h0, 1'b1);
		en = 1'b0;
		trig(32'h00ff_8007, 3'h2, 1'b1);
		rd(SID_OFF_CTRL, 32'h0);
		bus(1'b1, SID_OFF_CTRL, 32'h1, 3'h0, 1'b1);
		en = 1'b1;
		trig(32'h0200_0009, 3'h3, 1'b0);
		rd(SID_OFF_STATUS, {cnt[15:0], 16'h0} | lst);
		@(posedge mclk);
		bus_wr <= 1'b0;
		bus_rd <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			chk("pending", {16'h0, epend[i]}, {16'h0, pend_q[i]});
		end
		stop_test();
	end
endmodule // soft_irq_dispatch_tb
`default_nettype wire
